//--- hw/bmu_pkg.sv
// Shared types and constants of the bit manipulation unit
package bmu_pkg;

	// ==========================================
	// Widths
	localparam int BYTE_W = 8;
	localparam int POS_W = 3;
	localparam int ADDR_W = 16;

	// ==========================================
	// Values after reset
	localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
	localparam logic [POS_W-1:0] RST_POS = 3'h0;
	localparam logic [ADDR_W-1:0] RST_ADDR = 16'h0000;
	localparam logic RST_FLAG = 1'b0;

	// ==========================================
	// Operation codes
	typedef enum logic [3:0] {
		bit_set_op = 4'h0,
		bit_clear_op = 4'h1,
		bit_invert_op = 4'h2,
		bit_test_op = 4'h3,
		carry_and_bit_op = 4'h4,
		carry_and_inverted_bit_op = 4'h5,
		carry_or_bit_op = 4'h6,
		carry_or_inverted_bit_op = 4'h7,
		carry_xor_bit_op = 4'h8,
		carry_xor_inverted_bit_op = 4'h9,
		bit_to_carry_op = 4'hA,
		inverted_bit_to_carry_op = 4'hB,
		carry_to_bit_op = 4'hC,
		inverted_carry_to_bit_op = 4'hD
	} bmu_op_e;

	// ==========================================
	// Sequencer states, Gray along idle-fetch-exec-store
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_FETCH = 2'h1,
		ST_EXEC = 2'h3,
		ST_STORE = 2'h2
	} bmu_state_e;

endpackage

//--- hw/bmu_core.sv
// Bit manipulation unit: datapath and sequencer for single-bit byte operations
//
// Functional notes
// RULE1 - Set, clear, invert, test take position from immediate or register low bits.
// RULE2 - Set forces selected bit to one, other seven bits kept.
// RULE3 - Clear forces selected bit to zero, other bits kept.
// RULE4 - Invert complements selected bit, other bits kept.
// RULE5 - Test loads zero flag with inverse of selected bit; operand untouched.
// RULE6 - Carry becomes carry AND selected bit.
// RULE7 - Carry becomes carry AND inverse of selected bit.
// RULE8 - Carry becomes carry OR selected bit.
// RULE9 - Carry becomes carry OR inverse of selected bit.
// RULE10 - Carry becomes carry XOR selected bit.
// RULE11 - Carry becomes carry XOR inverse of selected bit.
// RULE12 - Carry takes selected bit; operand untouched.
// RULE13 - Carry takes inverse of selected bit; operand untouched.
// RULE14 - Selected bit takes carry; other bits kept.
// RULE15 - Selected bit takes inverse of carry; other bits kept.
// RULE16 - Inverted variants accept only an immediate 3-bit position.
// RULE17 - Memory modify reads whole byte, alters one bit, writes whole byte.
// RULE18 - Register position ignores upper five bits; unnamed flags stay unchanged.
`timescale 1ns/1ps
`default_nettype none

module bmu_core #(
	parameter int BYTE_BITS = bmu_pkg::BYTE_W,
	parameter int ADDR_BITS = bmu_pkg::ADDR_W
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic START,
	input wire bmu_pkg::bmu_op_e OP,
	input wire logic POS_FROM_REG,
	input wire logic [bmu_pkg::POS_W-1:0] BIT_IMM,
	input wire logic [bmu_pkg::BYTE_W-1:0] POS_REG,
	input wire logic OPND_IN_MEM,
	input wire logic [bmu_pkg::BYTE_W-1:0] REG_DATA,
	input wire logic [bmu_pkg::ADDR_W-1:0] MEM_ADDR_IN,
	input wire logic CARRY_IN,
	input wire logic [bmu_pkg::BYTE_W-1:0] MEM_RDATA,
	input wire logic MEM_READY,
	output logic BUSY,
	output logic DONE,
	output logic REFUSED,
	output logic [bmu_pkg::BYTE_W-1:0] RESULT,
	output logic RESULT_WE,
	output logic CARRY_OUT,
	output logic CARRY_WE,
	output logic ZERO_OUT,
	output logic ZERO_WE,
	output logic [bmu_pkg::ADDR_W-1:0] MEM_ADDR,
	output logic MEM_RD,
	output logic MEM_WR,
	output logic [bmu_pkg::BYTE_W-1:0] MEM_WDATA
);
	import bmu_pkg::*;

	// ==========================================
	// Elaboration checks
	// The bit select is fixed at three bits, so only byte operands fit
	if (BYTE_BITS != BYTE_W) begin : g_bad_width
		$error("bmu_core serves 8-bit operands only");
	end
	if (ADDR_BITS != ADDR_W) begin : g_bad_addr
		$error("bmu_core address width must match the package");
	end

	// ==========================================
	// State
	typedef struct packed {
		bmu_state_e st;
		bmu_op_e op;
		logic [POS_W-1:0] pos;
		logic in_mem;
		logic carry;
		logic [BYTE_W-1:0] data;
		logic busy;
		logic done;
		logic refused;
		logic [BYTE_W-1:0] result;
		logic result_we;
		logic carry_out;
		logic carry_we;
		logic zero_out;
		logic zero_we;
		logic [ADDR_W-1:0] mem_addr;
		logic mem_rd;
		logic mem_wr;
		logic [BYTE_W-1:0] mem_wdata;
	} bmu_regs_s;

	bmu_regs_s cur;
	bmu_regs_s next_cur;

	// ==========================================
	// Operation classes
	logic reg_pos_ok;
	logic sel_bit;
	logic put_val;
	logic [BYTE_W-1:0] new_byte;
	logic writes_byte;
	logic new_carry;
	logic carry_op;

	always_comb begin
		// Only the four plain single-bit ops accept a register position
		case (OP)
			bit_set_op, bit_clear_op, bit_invert_op, bit_test_op: reg_pos_ok = 1'b1; // RULE1
			default: reg_pos_ok = 1'b0; // RULE16
		endcase
	end

	always_comb begin
		sel_bit = cur.data[cur.pos];
		put_val = 1'h0;
		writes_byte = 1'b0;
		new_carry = cur.carry;
		carry_op = 1'b0;
		case (cur.op)
			bit_set_op: begin
				put_val = 1'h1; // RULE2
				writes_byte = 1'b1;
			end
			bit_clear_op: begin
				put_val = 1'h0; // RULE3
				writes_byte = 1'b1;
			end
			bit_invert_op: begin
				put_val = ~sel_bit; // RULE4
				writes_byte = 1'b1;
			end
			bit_test_op: begin
				// Operand stays as read
			end
			carry_and_bit_op: begin
				new_carry = cur.carry & sel_bit; // RULE6
				carry_op = 1'b1;
			end
			carry_and_inverted_bit_op: begin
				new_carry = cur.carry & ~sel_bit; // RULE7
				carry_op = 1'b1;
			end
			carry_or_bit_op: begin
				new_carry = cur.carry | sel_bit; // RULE8
				carry_op = 1'b1;
			end
			carry_or_inverted_bit_op: begin
				new_carry = cur.carry | ~sel_bit; // RULE9
				carry_op = 1'b1;
			end
			carry_xor_bit_op: begin
				new_carry = cur.carry ^ sel_bit; // RULE10
				carry_op = 1'b1;
			end
			carry_xor_inverted_bit_op: begin
				new_carry = cur.carry ^ ~sel_bit; // RULE11
				carry_op = 1'b1;
			end
			bit_to_carry_op: begin
				new_carry = sel_bit; // RULE12
				carry_op = 1'b1;
			end
			inverted_bit_to_carry_op: begin
				new_carry = ~sel_bit; // RULE13
				carry_op = 1'b1;
			end
			carry_to_bit_op: begin
				put_val = cur.carry; // RULE14
				writes_byte = 1'b1;
			end
			inverted_carry_to_bit_op: begin
				put_val = ~cur.carry; // RULE15
				writes_byte = 1'b1;
			end
			default: begin
				put_val = 1'h0;
			end
		endcase
	end

	// ==========================================
	// Single-bit insertion shared by every byte-writing op
	bmu_bit_put #(
		.WIDTH(BYTE_W),
		.SEL_W(POS_W)
	) bmu_bit_put_i (
		.word_in(cur.data),
		.sel(cur.pos),
		.val(put_val),
		.word_out(new_byte)
	);

	// ==========================================
	// Sequencer
	always_comb begin
		next_cur = cur;
		// Strobes last one cycle
		next_cur.done = 1'b0;
		next_cur.refused = 1'b0;
		next_cur.result_we = 1'b0;
		next_cur.carry_we = 1'b0;
		next_cur.zero_we = 1'b0;
		case (cur.st)
			ST_IDLE: begin
				// START while busy is never seen here, so it is simply ignored
				if (START) begin
					if (POS_FROM_REG && !reg_pos_ok) begin
						// Refused: nothing read, nothing written, no flag touched
						next_cur.done = 1'b1; // RULE16
						next_cur.refused = 1'b1; // RULE16
					end else begin
						next_cur.op = OP;
						// Upper five bits of the position register are dropped
						next_cur.pos = POS_FROM_REG ? POS_REG[POS_W-1:0] : BIT_IMM; // RULE1 RULE18
						next_cur.in_mem = OPND_IN_MEM;
						next_cur.carry = CARRY_IN;
						next_cur.data = REG_DATA;
						next_cur.busy = 1'b1;
						if (OPND_IN_MEM) begin
							next_cur.mem_addr = MEM_ADDR_IN;
							next_cur.mem_rd = 1'b1; // RULE17
							next_cur.st = ST_FETCH;
						end else begin
							next_cur.st = ST_EXEC;
						end
					end
				end
			end
			ST_FETCH: begin
				// Whole byte is read before any bit is touched
				if (MEM_READY) begin
					next_cur.data = MEM_RDATA; // RULE17
					next_cur.mem_rd = 1'b0;
					next_cur.st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				// Only the flag the op names gets a write strobe
				if (cur.op == bit_test_op) begin
					next_cur.zero_out = ~sel_bit; // RULE5
					next_cur.zero_we = 1'b1; // RULE18
				end
				if (carry_op) begin
					next_cur.carry_out = new_carry;
					next_cur.carry_we = 1'b1; // RULE18
				end
				if (writes_byte && cur.in_mem) begin
					// Full byte goes back, untouched bits as read
					next_cur.mem_wdata = new_byte; // RULE17
					next_cur.mem_wr = 1'b1; // RULE17
					next_cur.st = ST_STORE;
				end else begin
					if (writes_byte) begin
						next_cur.result = new_byte;
						next_cur.result_we = 1'b1;
					end
					next_cur.done = 1'b1;
					next_cur.busy = 1'b0;
					next_cur.st = ST_IDLE;
				end
			end
			ST_STORE: begin
				if (MEM_READY) begin
					next_cur.mem_wr = 1'b0;
					next_cur.result = cur.mem_wdata;
					next_cur.done = 1'b1;
					next_cur.busy = 1'b0;
					next_cur.st = ST_IDLE;
				end
			end
			default: begin
				next_cur.st = ST_IDLE;
				next_cur.busy = 1'b0;
				next_cur.mem_rd = 1'b0;
				next_cur.mem_wr = 1'b0;
			end
		endcase
		if (SYS_RST) begin
			next_cur = '0;
			next_cur.st = ST_IDLE;
			next_cur.op = bit_set_op;
			next_cur.pos = RST_POS;
			next_cur.carry = RST_FLAG;
			next_cur.data = RST_BYTE;
			next_cur.result = RST_BYTE;
			next_cur.carry_out = RST_FLAG;
			next_cur.zero_out = RST_FLAG;
			next_cur.mem_addr = RST_ADDR;
			next_cur.mem_wdata = RST_BYTE;
		end
	end

	always_ff @(posedge CLK) begin
		cur <= next_cur;
	end

	// ==========================================
	// Outputs, each straight from the state register
	assign BUSY = cur.busy;
	assign DONE = cur.done;
	assign REFUSED = cur.refused;
	assign RESULT = cur.result;
	assign RESULT_WE = cur.result_we;
	assign CARRY_OUT = cur.carry_out;
	assign CARRY_WE = cur.carry_we;
	assign ZERO_OUT = cur.zero_out;
	assign ZERO_WE = cur.zero_we;
	assign MEM_ADDR = cur.mem_addr;
	assign MEM_RD = cur.mem_rd;
	assign MEM_WR = cur.mem_wr;
	assign MEM_WDATA = cur.mem_wdata;

endmodule

// ==========================================
// Writes one bit value into the selected position of a word
module bmu_bit_put #(
	parameter int WIDTH = 8,
	parameter int SEL_W = 3
) (
	input wire logic [WIDTH-1:0] word_in,
	input wire logic [SEL_W-1:0] sel,
	input wire logic val,
	output wire logic [WIDTH-1:0] word_out
);
	// A narrow select could never reach the top bits
	if (WIDTH > (1 << SEL_W)) begin : g_bad_sel
		$error("bmu_bit_put select too narrow for its word");
	end
	if (WIDTH < 1) begin : g_bad_width
		$error("bmu_bit_put needs at least one bit");
	end

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		// Every other bit passes through as it came
		assign word_out[i] = (sel == SEL_W'(i)) ? val : word_in[i];
	end
endmodule

`default_nettype wire

//--- test/bmu_props.sv
// Port assertions for the bit manipulation unit
`timescale 1ns/1ps
`default_nettype none
module bmu_props
	import bmu_pkg::*;
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic START,
	input wire bmu_pkg::bmu_op_e OP,
	input wire logic POS_FROM_REG,
	input wire logic [2:0] BIT_IMM,
	input wire logic [7:0] POS_REG,
	input wire logic OPND_IN_MEM,
	input wire logic [7:0] REG_DATA,
	input wire logic CARRY_IN,
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic REFUSED,
	input wire logic [7:0] RESULT,
	input wire logic RESULT_WE,
	input wire logic CARRY_OUT,
	input wire logic CARRY_WE,
	input wire logic ZERO_OUT,
	input wire logic ZERO_WE
);
	// ==========================================
	// Operand captured at the take edge
	logic take;
	logic rg;
	logic b_q;
	logic c_q;
	logic [7:0] d_q;
	logic [7:0] m_q;
	assign take = START && !BUSY && !SYS_RST;
	assign rg = take && !OPND_IN_MEM && (!POS_FROM_REG || OP < carry_and_bit_op);
	assign b_q = |(d_q & m_q);
	always_ff @(posedge CLK) begin
		if (take) begin
			d_q <= REG_DATA;
			m_q <= 8'h01 << (POS_FROM_REG ? POS_REG[2:0] : BIT_IMM);
			c_q <= CARRY_IN;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// ==========================================
	// Register operand results two edges after take, register position refusal one edge after take
	property p_set;
		rg && OP == bit_set_op |-> ##2 DONE && RESULT_WE && RESULT == (d_q | m_q);
	endproperty
	a_set: assert property (p_set) else $error("set result wrong");
	property p_clr;
		rg && OP == bit_clear_op |-> ##2 RESULT_WE && RESULT == (d_q & ~m_q);
	endproperty
	a_clr: assert property (p_clr) else $error("clear result wrong");
	property p_inv;
		rg && OP == bit_invert_op |-> ##2 RESULT_WE && RESULT == (d_q ^ m_q);
	endproperty
	a_inv: assert property (p_inv) else $error("invert result wrong");
	property p_tst;
		rg && OP == bit_test_op |-> ##2 ZERO_WE && ZERO_OUT == !b_q && !RESULT_WE && !CARRY_WE;
	endproperty
	a_tst: assert property (p_tst) else $error("test flag wrong");
	property p_ixor;
		rg && OP == carry_xor_inverted_bit_op |-> ##2 CARRY_WE && CARRY_OUT == (c_q ^ !b_q);
	endproperty
	a_ixor: assert property (p_ixor) else $error("inverted xor carry wrong");
	property p_ld;
		rg && OP == bit_to_carry_op |-> ##1 !DONE ##1 CARRY_WE && CARRY_OUT == b_q && !RESULT_WE;
	endproperty
	a_ld: assert property (p_ld) else $error("bit load carry wrong");
	property p_ist;
		rg && OP == inverted_carry_to_bit_op |-> ##2 RESULT == (c_q ? d_q & ~m_q : d_q | m_q);
	endproperty
	a_ist: assert property (p_ist) else $error("inverted store wrong");
	property p_ref;
		take && POS_FROM_REG && OP > bit_test_op |=> DONE && REFUSED && !BUSY && !CARRY_WE;
	endproperty
	a_ref: assert property (p_ref) else $error("register position not refused");
	c_set: cover property (rg && OP == bit_set_op);
	c_ref: cover property (take && POS_FROM_REG && OP > bit_test_op ##1 REFUSED);
	c_mem: cover property (take && OPND_IN_MEM);
endmodule
`default_nettype wire

//--- test/tb.sv
// Random and corner-case bench for the bit manipulation unit
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bmu_pkg::*;
	logic CLK = 1'h0, SYS_RST = 1'h1, START = 1'h0, POS_FROM_REG = 1'h0, OPND_IN_MEM = 1'h0;
	logic CARRY_IN = 1'h0, MEM_READY = 1'h0;
	bmu_op_e OP = bit_set_op;
	logic [2:0] BIT_IMM = 3'h0;
	logic [7:0] POS_REG = 8'h00, REG_DATA = 8'h00, MEM_RDATA = 8'h00, RESULT, MEM_WDATA;
	logic [15:0] MEM_ADDR_IN = 16'h0000, MEM_ADDR;
	logic BUSY, DONE, REFUSED, RESULT_WE, CARRY_OUT, CARRY_WE, ZERO_OUT, ZERO_WE, MEM_RD, MEM_WR;
	int err_count = 0, checks_done = 0;
	always #50 CLK = ~CLK;
	bmu_core bmu_core_i (
		.CLK(CLK),
		.SYS_RST(SYS_RST),
		.START(START),
		.OP(OP),
		.POS_FROM_REG(POS_FROM_REG),
		.BIT_IMM(BIT_IMM),
		.POS_REG(POS_REG),
		.OPND_IN_MEM(OPND_IN_MEM),
		.REG_DATA(REG_DATA),
		.MEM_ADDR_IN(MEM_ADDR_IN),
		.CARRY_IN(CARRY_IN),
		.MEM_RDATA(MEM_RDATA),
		.MEM_READY(MEM_READY),
		.BUSY(BUSY),
		.DONE(DONE),
		.REFUSED(REFUSED),
		.RESULT(RESULT),
		.RESULT_WE(RESULT_WE),
		.CARRY_OUT(CARRY_OUT),
		.CARRY_WE(CARRY_WE),
		.ZERO_OUT(ZERO_OUT),
		.ZERO_WE(ZERO_WE),
		.MEM_ADDR(MEM_ADDR),
		.MEM_RD(MEM_RD),
		.MEM_WR(MEM_WR),
		.MEM_WDATA(MEM_WDATA)
	);
	// ==========================================
	// Compare, verdict and expectation helpers
	task automatic check_byte(string what, logic [7:0] exp, logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_addr(string what, logic [15:0] exp, logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_bit(string what, logic exp, logic got);
		check_byte(what, {7'h00, exp}, {7'h00, got});
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	function automatic logic [7:0] exp_byte(bmu_op_e op, logic [7:0] d, logic [2:0] p, logic c);
		logic [7:0] m;
		m = 8'h01 << p;
		case (op)
			bit_set_op: return d | m;
			bit_clear_op: return d & ~m;
			bit_invert_op: return d ^ m;
			carry_to_bit_op: return c ? d | m : d & ~m;
			default: return c ? d & ~m : d | m;
		endcase
	endfunction
	function automatic logic exp_carry(bmu_op_e op, logic b, logic c);
		case (op)
			carry_and_bit_op: return c & b;
			carry_and_inverted_bit_op: return c & ~b;
			carry_or_bit_op: return c | b;
			carry_or_inverted_bit_op: return c | ~b;
			carry_xor_bit_op: return c ^ b;
			carry_xor_inverted_bit_op: return c ^ ~b;
			bit_to_carry_op: return b;
			default: return ~b;
		endcase
	endfunction
	// ==========================================
	// One operation; memory answers with random wait states
	task automatic run_op(bmu_op_e op, logic fr, logic [2:0] imm, logic [7:0] pr, logic mem,
		logic [7:0] d, logic c);
		logic [2:0] p;
		logic [15:0] a;
		logic rf, md, cy, wr, rd;
		int n;
		p = fr ? pr[2:0] : imm;
		a = 16'($urandom);
		rd = 1'h0;
		rf = fr && op > bit_test_op;
		md = !rf && op inside {[bit_set_op:bit_invert_op], carry_to_bit_op, inverted_carry_to_bit_op};
		cy = !rf && op inside {[carry_and_bit_op:inverted_bit_to_carry_op]};
		wr = 1'h0;
		n = 0;
		@(negedge CLK);
		OP = op;
		POS_FROM_REG = fr;
		BIT_IMM = imm;
		POS_REG = pr;
		OPND_IN_MEM = mem;
		// Register copy differs from memory so a skipped fetch shows
		REG_DATA = mem ? ~d : d;
		MEM_ADDR_IN = a;
		CARRY_IN = c;
		START = 1'h1;
		@(negedge CLK);
		START = 1'h0;
		while (DONE !== 1'h1 && n < 40) begin
			// Stale read data is inverted so a late capture shows
			check_bit("busy", 1'h1, BUSY);
			MEM_RDATA = MEM_RD ? d : ~d;
			if (MEM_RD === 1'h1) rd = 1'h1;
			if (MEM_RD === 1'h1 || MEM_WR === 1'h1) check_addr("mem_addr", a, MEM_ADDR);
			if (MEM_WR === 1'h1) begin
				wr = 1'h1;
				check_byte("mem_wdata", exp_byte(op, d, p, c), MEM_WDATA);
			end
			MEM_READY = 1'($urandom_range(1, 0));
			@(negedge CLK);
			n++;
		end
		check_bit("done", 1'h1, DONE);
		check_bit("busy", 1'h0, BUSY);
		check_bit("refused", rf, REFUSED);
		if (rf || !mem) check_bit("latency", 1'h1, n == (rf ? 0 : 1));
		check_bit("mem_read", !rf && mem, rd);
		check_bit("mem_write", md && mem, wr);
		check_bit("result_we", md && !mem, RESULT_WE);
		check_bit("carry_we", cy, CARRY_WE);
		check_bit("zero_we", !rf && op == bit_test_op, ZERO_WE);
		if (md) check_byte("result", exp_byte(op, d, p, c), RESULT);
		if (cy) check_bit("carry", exp_carry(op, d[p], c), CARRY_OUT);
		if (!rf && op == bit_test_op) check_bit("zero", ~d[p], ZERO_OUT);
	endtask
	initial begin
		#2000000;
		err_count++;
		give_verdict();
	end
	initial begin
		void'($urandom(7));
		repeat (10) @(negedge CLK);
		SYS_RST = 1'h0;
		run_op(bit_set_op, 1'h1, 3'h0, 8'hFA, 1'h0, 8'h00, 1'h0);
		for (int o = 0; o < 16; o++) begin
			run_op(bmu_op_e'(o), 1'h0, 3'h7, 8'hF8, 1'h0, 8'h5A, o[0]);
			run_op(bmu_op_e'(o), 1'h1, 3'h0, 8'h07, 1'h0, 8'hA5, o[1]);
			run_op(bmu_op_e'(o), 1'h0, 3'h0, 8'h00, 1'h1, 8'hC3, o[2]);
		end
		repeat (200) begin
			run_op(bmu_op_e'($urandom_range(13, 0)), 1'($urandom), 3'($urandom), 8'($urandom),
				1'($urandom), 8'($urandom), 1'($urandom));
		end
		give_verdict();
	end
endmodule
bind bmu_core bmu_props bmu_props_i (
	.CLK(CLK),
	.SYS_RST(SYS_RST),
	.START(START),
	.OP(OP),
	.POS_FROM_REG(POS_FROM_REG),
	.BIT_IMM(BIT_IMM),
	.POS_REG(POS_REG),
	.OPND_IN_MEM(OPND_IN_MEM),
	.REG_DATA(REG_DATA),
	.CARRY_IN(CARRY_IN),
	.BUSY(BUSY),
	.DONE(DONE),
	.REFUSED(REFUSED),
	.RESULT(RESULT),
	.RESULT_WE(RESULT_WE),
	.CARRY_OUT(CARRY_OUT),
	.CARRY_WE(CARRY_WE),
	.ZERO_OUT(ZERO_OUT),
	.ZERO_WE(ZERO_WE)
);
`default_nettype wire
